// ---- pcs_core_model.sv ----
// core decoder stand-in issuing command pulses of one cycle or held for n cycles
`timescale 1ns/1ps
`default_nettype none
module pcs_core_model (
  input  wire logic        mclk,
  output logic      [6:0]  cmd,
  output logic      [10:0] target
);
  // idle from time zero
  initial begin
    cmd = 7'h00;
    target = 11'h000;
  end
  // one command for exactly one cycle, then idle
  task automatic issue(input int op, input logic [10:0] tgt);
    @(posedge mclk);
    cmd <= 7'(7'h01 << op);
    target <= tgt;
    @(posedge mclk);
    cmd <= 7'h00;
  endtask
  // the same command held for n cycles in a row
  task automatic burst(input int op, input int n, input logic [10:0] tgt);
    @(posedge mclk);
    cmd <= 7'(7'h01 << op);
    target <= tgt;
    repeat (n) @(posedge mclk);
    cmd <= 7'h00;
  endtask
  // two commands on consecutive cycles
  task automatic pair(input int op_a, input int op_b, input logic [10:0] tgt);
    @(posedge mclk);
    cmd <= 7'(7'h01 << op_a);
    target <= tgt;
    @(posedge mclk);
    cmd <= 7'(7'h01 << op_b);
    @(posedge mclk);
    cmd <= 7'h00;
  endtask
endmodule
`default_nettype wire

// ---- pcs_pkg.sv ----
// package: constants for the program counter and return stack unit
package pcs_pkg;
  // ************************************************************
  // widths and depths
  // ************************************************************
  localparam int PC_W        = 13;
  localparam int STACK_DEPTH = 8;
  localparam int TARGET_W    = 11;
  localparam int LATCH_W     = 5;
  localparam int ADDR_W      = 8;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_PC_LOW   = 8'h00;
  localparam logic [7:0] OFF_PC_LATCH = 8'h04;
  localparam logic [7:0] OFF_PC_STAT  = 8'h08;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int LOW_MSB     = 7;
  localparam int HIGH_LSB    = 8;
  localparam int PAGE_BIT    = 3;
  // ************************************************************
  // reset values and interrupt vector
  // ************************************************************
  localparam logic [12:0] PC_RST    = 13'h0000;
  localparam logic [4:0]  LATCH_RST = 5'h00;
  localparam logic [2:0]  SP_RST    = 3'h0;
  localparam logic [12:0] INT_VEC   = 13'h0004;
endpackage

// ---- pcs_top.sv ----
// module: program counter, high latch and circular return stack with apb access
`timescale 1ns/1ps
`default_nettype none
// Function
// - a 13-bit program counter holds the address of the next instruction to fetch.
// - the low byte of the counter is a register that software reads and writes.
// - counter bits 12 to 8 sit in a hidden high part with no direct software access.
// - software changes the hidden high part only by transfer from the high latch register.
// - an eight-entry return stack lies outside program and data space with a hidden pointer.
// - a call or an interrupt branch pushes the current counter onto the stack.
// - a return, a return with literal or a return from interrupt pops the stack into the counter.
// - pushes and pops leave the high latch register unchanged.
// - the stack is circular without overflow flag, so the ninth push replaces the first.
// - call and goto take 11 target bits, reaching anywhere inside one 2K page.
// - for call and goto the page bit 11 of the target comes from latch bit 3.
// - a return restores the whole 13-bit counter from the stack, ignoring the page bit.
module pcs_top #(
  parameter int PC_W        = pcs_pkg::PC_W,
  parameter int STACK_DEPTH = pcs_pkg::STACK_DEPTH,
  parameter int TARGET_W    = pcs_pkg::TARGET_W
) (
  input  wire logic                        MCLK,
  input  wire logic                        RST,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [pcs_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]                 PWDATA,
  output logic      [31:0]                 PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  input  wire logic                        STEP,
  input  wire logic                        JUMP,
  input  wire logic                        CALL,
  input  wire logic [TARGET_W-1:0]         TARGET,
  input  wire logic                        INTR,
  input  wire logic                        RET,
  input  wire logic                        RET_LIT,
  input  wire logic                        RET_INT,
  output logic      [PC_W-1:0]             FETCH_ADDR
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  // ************************************************************
  // state
  // ************************************************************
  logic [PC_W-1:0]              pc_q;
  logic [PC_W-1:0]              pc_d;
  logic [pcs_pkg::LATCH_W-1:0]  latch_q;
  logic [SP_W-1:0]              sp_q;
  logic [31:0]                  prdata_q;
  logic [PC_W-1:0]              stack_mem [STACK_DEPTH];

  // true when the bus address selects the given register
  function automatic logic addr_hit(input logic [pcs_pkg::ADDR_W-1:0] addr,
                                    input logic [7:0]                 off);
    return addr == off;
  endfunction

  // ************************************************************
  // apb decode
  // ************************************************************
  wire logic        access   = PSEL & PENABLE;
  wire logic        setup_rd = PSEL & ~PENABLE & ~PWRITE;
  wire logic        hit_low  = addr_hit(PADDR, pcs_pkg::OFF_PC_LOW);
  wire logic        hit_lat  = addr_hit(PADDR, pcs_pkg::OFF_PC_LATCH);
  wire logic        hit_stat = addr_hit(PADDR, pcs_pkg::OFF_PC_STAT);
  wire logic        hit_any  = hit_low | hit_lat | hit_stat;
  wire logic        wr_low   = access & PWRITE & hit_low;
  wire logic        wr_lat   = access & PWRITE & hit_lat;
  // read data is captured in the setup cycle, so the access needs no wait state
  // status offset reads zero: the hidden high part never reaches the bus
  wire logic [31:0] rd_mux   =
    hit_low  ? {24'h000000, pc_q[pcs_pkg::LOW_MSB:0]} :
    hit_lat  ? {27'h0, latch_q} :
    32'h00000000;

  // zero wait states, error only on unmapped offsets
  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~hit_any;
  assign PRDATA  = prdata_q;
  assign FETCH_ADDR = pc_q;

  // ************************************************************
  // core command decode
  // ************************************************************
  // one source per edge; a losing low byte write still ends normally on the bus
  wire logic            pop      = RET | RET_LIT | RET_INT;
  wire logic            do_int   = INTR;
  wire logic            do_pop   = ~INTR & pop;
  wire logic            do_call  = ~INTR & ~pop & CALL;
  wire logic            do_jump  = ~INTR & ~pop & ~CALL & JUMP;
  wire logic            do_wlow  = ~INTR & ~pop & ~CALL & ~JUMP & wr_low;
  wire logic            do_step  = ~INTR & ~pop & ~CALL & ~JUMP & ~wr_low & STEP;
  wire logic            do_push  = do_int | do_call;
  wire logic [SP_W-1:0] sp_dec   = SP_W'(sp_q - SP_W'(1));
  wire logic [SP_W-1:0] sp_inc   = SP_W'(sp_q + SP_W'(1));
  // page bits from the latch, offset from the instruction
  wire logic [PC_W-1:0] page_tgt =
    {latch_q[4:pcs_pkg::PAGE_BIT], TARGET};
  // whole counter from the stack, latch not consulted
  wire logic [PC_W-1:0] pop_val  = stack_mem[sp_dec];
  // low byte write pulls the high part from the latch
  wire logic [PC_W-1:0] wlow_val =
    {latch_q, PWDATA[pcs_pkg::LOW_MSB:0]};

  // next program counter, one source per cycle by priority
  assign pc_d = do_int  ? pcs_pkg::INT_VEC :
                do_pop  ? pop_val :
                (do_call | do_jump) ? page_tgt :
                do_wlow ? wlow_val :
                do_step ? PC_W'(pc_q + PC_W'(1)) : pc_q;

  // ************************************************************
  // registers
  // ************************************************************
  // counter and read data
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pc_q     <= pcs_pkg::PC_RST;
      prdata_q <= 32'h00000000;
    end else begin
      pc_q <= pc_d;
      if (setup_rd) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // high latch, only software writes touch it
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      latch_q <= pcs_pkg::LATCH_RST;
    end else if (wr_lat) begin
      latch_q <= PWDATA[pcs_pkg::LATCH_W-1:0];
    end
  end

  // stack pointer wraps with no overflow indication
  // a pop of an empty stack just wraps and returns whatever entry sits there
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sp_q <= pcs_pkg::SP_RST;
    end else if (do_push) begin
      sp_q <= sp_inc;
    end else if (do_pop) begin
      sp_q <= sp_dec;
    end
  end

  // stack storage, not mapped to any bus address
  // no reset: entries are unknown until pushed and software never sees them
  always_ff @(posedge MCLK) begin
    if (do_push) begin
      stack_mem[sp_q] <= pc_q;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  AST_STEP_INC: assert property (@(posedge MCLK) disable iff (RST)
    do_step |=> pc_q == PC_W'($past(pc_q) + PC_W'(1)))
    else $error("step did not advance the counter by one");

  AST_LOW_WRITE: assert property (@(posedge MCLK) disable iff (RST)
    do_wlow |=> pc_q == {$past(latch_q), $past(PWDATA[7:0])})
    else $error("low byte write did not load counter from latch");

  AST_LOW_READ: assert property (@(posedge MCLK) disable iff (RST)
    (setup_rd && hit_low) |=> PRDATA == {24'h000000, $past(pc_q[7:0])})
    else $error("low byte read returned wrong value");

  AST_HIGH_SRC: assert property (@(posedge MCLK) disable iff (RST)
    ($changed(pc_q[12:8]) && !$past(do_int | do_pop | do_call | do_jump | do_wlow))
      |-> $past(do_step) && $past(pc_q[7:0]) == 8'hff)
    else $error("hidden high part changed without a legal source");

  AST_PAGE_TGT: assert property (@(posedge MCLK) disable iff (RST)
    (do_call || do_jump) |=> pc_q == {$past(latch_q[4:3]), $past(TARGET)})
    else $error("call or goto target not paged by latch");

  AST_LATCH_KEEP: assert property (@(posedge MCLK) disable iff (RST)
    ((do_push || do_pop) && !wr_lat) |=> $stable(latch_q))
    else $error("latch moved on push or pop");

  AST_CALL_RET: assert property (@(posedge MCLK) disable iff (RST)
    (do_call ##1 do_pop) |=> pc_q == $past(pc_q, 2))
    else $error("return did not restore the pushed counter");

  AST_INT_VEC: assert property (@(posedge MCLK) disable iff (RST)
    do_int |=> pc_q == pcs_pkg::INT_VEC && sp_q == SP_W'($past(sp_q) + SP_W'(1)))
    else $error("interrupt branch did not push and vector");

  AST_WRAP: assert property (@(posedge MCLK) disable iff (RST)
    do_push [*8] |=> sp_q == $past(sp_q, 8))
    else $error("stack pointer did not wrap after eight pushes");

  AST_POP_PTR: assert property (@(posedge MCLK) disable iff (RST)
    do_pop |=> sp_q == SP_W'($past(sp_q) - SP_W'(1)) && pc_q == $past(pop_val))
    else $error("pop did not load the top entry");

  // ************************************************************
  // assertions: bus access and high latch
  // ************************************************************

  AST_HIDE_HIGH: assert property (@(posedge MCLK) disable iff (RST)
    (setup_rd && !hit_low && !hit_lat) |=> PRDATA == 32'h00000000)
    else $error("hidden high part visible on the bus");

  AST_STAT_WRITE: assert property (@(posedge MCLK) disable iff (RST)
    (access && PWRITE && !hit_low && !do_int && !do_pop && !do_call && !do_jump && !do_step)
      |=> $stable(pc_q))
    else $error("bus write outside the low byte moved the counter");

  AST_HIGH_FROM_LATCH: assert property (@(posedge MCLK) disable iff (RST)
    do_wlow |=> pc_q[PC_W-1:pcs_pkg::HIGH_LSB] == $past(latch_q))
    else $error("high part not taken from the latch");

  AST_LATCH_WRITE: assert property (@(posedge MCLK) disable iff (RST)
    wr_lat |=> latch_q == $past(PWDATA[pcs_pkg::LATCH_W-1:0]))
    else $error("latch write did not land");

  AST_LATCH_READ: assert property (@(posedge MCLK) disable iff (RST)
    (setup_rd && hit_lat) |=> PRDATA == {27'h0, $past(latch_q)})
    else $error("latch read returned wrong value");

  AST_LATCH_HOLD: assert property (@(posedge MCLK) disable iff (RST)
    !wr_lat |=> $stable(latch_q))
    else $error("latch moved without a bus write");

  AST_WLOW_KEEP_LATCH: assert property (@(posedge MCLK) disable iff (RST)
    do_wlow |=> $stable(latch_q))
    else $error("low byte write disturbed the latch");

  AST_RD_HOLD: assert property (@(posedge MCLK) disable iff (RST)
    !setup_rd |=> $stable(PRDATA))
    else $error("read data moved outside a read setup");

  AST_ERR_PHASE: assert property (@(posedge MCLK) disable iff (RST)
    PSLVERR |-> (PSEL && PENABLE))
    else $error("error flag outside an access cycle");

  AST_LOW_NOERR: assert property (@(posedge MCLK) disable iff (RST)
    (PSEL && PENABLE && hit_low) |-> !PSLVERR)
    else $error("low byte access flagged as error");

  // ************************************************************
  // assertions: stack pointer and contents
  // ************************************************************

  AST_PTR_HOLD: assert property (@(posedge MCLK) disable iff (RST)
    (!do_push && !do_pop) |=> $stable(sp_q))
    else $error("stack pointer moved without push or pop");

  AST_PUSH_DATA: assert property (@(posedge MCLK) disable iff (RST)
    do_push |=> stack_mem[sp_dec] == $past(pc_q))
    else $error("push did not store the counter");

  AST_CALL_PTR: assert property (@(posedge MCLK) disable iff (RST)
    do_call |=> sp_q == SP_W'($past(sp_q) + SP_W'(1)))
    else $error("call did not push");

  AST_JUMP_NOPUSH: assert property (@(posedge MCLK) disable iff (RST)
    do_jump |=> $stable(sp_q))
    else $error("goto touched the stack");

  AST_RET_PLAIN: assert property (@(posedge MCLK) disable iff (RST)
    (RET && !INTR) |=> sp_q == SP_W'($past(sp_q) - SP_W'(1)))
    else $error("return did not pop");

  AST_RET_LIT: assert property (@(posedge MCLK) disable iff (RST)
    (RET_LIT && !INTR) |=> sp_q == SP_W'($past(sp_q) - SP_W'(1)))
    else $error("return with literal did not pop");

  AST_RET_INT: assert property (@(posedge MCLK) disable iff (RST)
    (RET_INT && !INTR) |=> sp_q == SP_W'($past(sp_q) - SP_W'(1)))
    else $error("return from interrupt did not pop");

  AST_SP_WRAP_UP: assert property (@(posedge MCLK) disable iff (RST)
    (do_push && sp_q == SP_W'(STACK_DEPTH - 1)) |=> sp_q == {SP_W{1'b0}})
    else $error("push at the top did not wrap");

  AST_SP_WRAP_DOWN: assert property (@(posedge MCLK) disable iff (RST)
    (do_pop && sp_q == {SP_W{1'b0}}) |=> sp_q == SP_W'(STACK_DEPTH - 1))
    else $error("pop at the bottom did not wrap");

  // ************************************************************
  // assertions: counter sources
  // ************************************************************

  AST_IDLE_HOLD: assert property (@(posedge MCLK) disable iff (RST)
    (!do_int && !do_pop && !do_call && !do_jump && !do_wlow && !do_step) |=> $stable(pc_q))
    else $error("counter moved with no command");

  AST_PAGE_LOW: assert property (@(posedge MCLK) disable iff (RST)
    (do_call || do_jump) |=> pc_q[TARGET_W-1:0] == $past(TARGET))
    else $error("target offset not taken from the instruction");

  AST_PAGE_BIT: assert property (@(posedge MCLK) disable iff (RST)
    (do_call || do_jump) |=> pc_q[TARGET_W] == $past(latch_q[pcs_pkg::PAGE_BIT]))
    else $error("page bit not taken from the latch");

endmodule
`default_nettype wire

// ---- test_program_counter_stack.sv ----
// testbench: apb and core commands against a reference model
`timescale 1ns/1ps
`default_nettype none
module test_program_counter_stack;
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, w;
  logic        pready, pslverr, er;
  logic [6:0]  cmd;
  logic [10:0] tgt;
  logic [12:0] fetch, pc, stk [8];
  logic [4:0]  lat;
  logic [2:0]  sp;
  int          n_errors = 0, checked = 0, cyc = 0;
  pcs_top dut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .STEP(cmd[0]), .JUMP(cmd[1]), .CALL(cmd[2]), .INTR(cmd[3]), .RET(cmd[4]),
    .RET_LIT(cmd[5]), .RET_INT(cmd[6]), .TARGET(tgt), .FETCH_ADDR(fetch));
  pcs_core_model core (.mclk(mclk), .cmd(cmd), .target(tgt));
  // 125 MHz clock and hang guard
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  // expected call and goto destination
  function automatic logic [12:0] paged(input logic [4:0] l, input logic [10:0] t);
    return {l[4:3], t};
  endfunction
  // core command with model update and fetch address check
  task op(input int k, input logic [10:0] t);
    core.issue(k, t);
    #1;
    case (k)
      0: pc = pc + 13'h1;
      1: pc = paged(lat, t);
      2, 3: begin
        stk[sp] = pc;
        sp = sp + 3'h1;
        pc = (k == 2) ? paged(lat, t) : pcs_pkg::INT_VEC;
      end
      default: begin
        sp = sp - 3'h1;
        pc = stk[sp];
      end
    endcase
    chk("fetch", 32'(fetch), 32'(pc));
  endtask
  initial begin
    void'($urandom(32'h086e0e9c));
    {pc, lat, sp} = 21'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk("fetch", 32'(fetch), 32'h0);
    apb(1'b0, pcs_pkg::OFF_PC_LATCH, 32'h0, rd, er);
    chk("latch", rd, 32'h0);
    $display("test reset done");
    repeat (4) begin
      lat = 5'($urandom);
      w = $urandom;
      apb(1'b1, pcs_pkg::OFF_PC_LATCH, 32'(lat), rd, er);
      apb(1'b1, pcs_pkg::OFF_PC_LOW, w, rd, er);
      pc = {lat, w[7:0]};
      chk("fetch", 32'(fetch), 32'(pc));
      apb(1'b0, pcs_pkg::OFF_PC_LOW, 32'h0, rd, er);
      chk("low", rd, 32'(pc[7:0]));
      apb(1'b1, pcs_pkg::OFF_PC_STAT, $urandom, rd, er);
      apb(1'b0, pcs_pkg::OFF_PC_STAT, 32'h0, rd, er);
      chk("status", rd, 32'h0);
      op(0, 11'h0);
      op(1, 11'($urandom));
    end
    $display("test low byte writes done");
    lat = 5'($urandom);
    apb(1'b1, pcs_pkg::OFF_PC_LATCH, 32'(lat), rd, er);
    for (int i = 0; i < 10; i++) op(2, 11'($urandom));
    op(3, 11'h0);
    for (int i = 0; i < 11; i++) op(4 + i % 3, 11'h0);
    apb(1'b0, pcs_pkg::OFF_PC_LATCH, 32'h0, rd, er);
    chk("latch", rd, 32'(lat));
    $display("test stack done");
    w = $urandom;
    core.burst(2, 9, w[10:0]);
    #1;
    repeat (9) begin
      stk[sp] = pc;
      sp = sp + 3'h1;
      pc = paged(lat, w[10:0]);
    end
    chk("burst", 32'(fetch), 32'(pc));
    for (int i = 0; i < 8; i++) op(4, 11'h0);
    core.pair(2, 5, w[10:0]);
    #1;
    stk[sp] = pc;
    chk("call return", 32'(fetch), 32'(pc));
    $display("test back to back done");
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    chk("error", 32'(er), 32'h1);
    chk("rdata", rd, 32'h0);
    $display("test unmapped done");
    final_report();
  end
endmodule
`default_nettype wire
